// file: design/gpt_pkg.sv
package gpt_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_TIMERS = 4;
    localparam int CNT_W      = 24;
    localparam int PAD_COUNT  = 36;
    localparam int PRE_W      = 7;   // largest ratio 128 needs 7 bits

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TMR_STRIDE   = 8'h10; // one block per timer
    localparam logic [1:0] REG_CFG      = 2'h0;  // word index in block
    localparam logic [1:0] REG_LOAD     = 2'h1;
    localparam logic [1:0] REG_STAT     = 2'h2;
    localparam logic [7:0] ADDR_INT_ST  = 8'h40;
    localparam logic [7:0] ADDR_INT_MSK = 8'h44;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK  = 32'h00FF_3F3F;
    localparam logic [23:0] LOAD_RESET = 24'hFF_FFFF;
    localparam logic [3:0]  MASK_RESET = 4'h0;

    // ------------------------------------------------------------
    // modes and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SHOT = 2'b00,
        MODE_FREE = 2'b01,
        MODE_CAPT = 2'b10
    } mode_e;

    typedef struct packed {
        logic [7:0] rsv_hi;
        logic [7:0] repeats;   // extra shots after the first
        logic [1:0] rsv_mid;
        logic [5:0] pad_sel;
        logic [1:0] rsv_lo;
        logic       enable;
        mode_e      mode;
        logic [2:0] prescale;
    } cfg_s;

    typedef struct packed {
        logic [6:0]       rsv;
        logic             running;
        logic [CNT_W-1:0] value;   // live count, or captured count
    } stat_s;

endpackage : gpt_pkg

// file: design/gpt_unit.sv
`timescale 1ns/10ps

module gpt_unit (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         reset_n_in,
    // control from register file
    input  wire gpt_pkg::cfg_s                cfg_in,
    input  wire logic [gpt_pkg::CNT_W-1:0]    load_in,
    input  wire logic                         start_in,
    input  wire logic                         pad_evt_in,
    // state back to register file
    output gpt_pkg::stat_s                    stat_out,
    output logic                              expire_out
);

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } state_e;

    state_e                         state_q, state_d;
    logic [gpt_pkg::PRE_W-1:0]      pre_q, pre_d, pre_mask;
    logic [gpt_pkg::CNT_W-1:0]      cnt_q, cnt_d, cap_q, cap_d;
    logic [7:0]                     shots_q, shots_d;
    logic                           exp_q, exp_d, tick;

    // ------------------------------------------------------------
    // prescaler: ratio is two to the power of the field
    // ------------------------------------------------------------
    assign pre_mask = gpt_pkg::PRE_W'((8'h01 << cfg_in.prescale) - 8'h01);
    assign tick     = (state_q == ST_RUN) && ((pre_q & pre_mask) == pre_mask);

    // next state of counter, shots and capture
    always_comb begin
        state_d = state_q;
        pre_d   = (state_q == ST_RUN) ? (tick ? '0 : pre_q + 1'b1) : '0;
        cnt_d   = cnt_q;
        cap_d   = cap_q;
        shots_d = shots_q;
        exp_d   = 1'b0;
        if (start_in) begin
            // restart reloads count and shots; the captured count is kept, so a stale capture can still show
            state_d = cfg_in.enable ? ST_RUN : ST_IDLE;
            pre_d   = '0;
            cnt_d   = (cfg_in.mode == gpt_pkg::MODE_CAPT) ? '0 : load_in;
            shots_d = cfg_in.repeats;
        end else if (state_q == ST_RUN) begin
            unique case (cfg_in.mode)
                gpt_pkg::MODE_SHOT: begin
                    if (tick) begin
                        if (cnt_q == '0) begin
                            exp_d = 1'b1;
                            cnt_d = load_in;
                            if (shots_q == 8'h00) begin
                                state_d = ST_IDLE;
                            end else begin
                                shots_d = shots_q - 8'h01;
                            end
                        end else begin
                            cnt_d = cnt_q - 1'b1;
                        end
                    end
                end
                gpt_pkg::MODE_FREE: begin
                    if (tick) begin
                        if (cnt_q == '0) begin
                            exp_d = 1'b1;
                            cnt_d = load_in;
                        end else begin
                            cnt_d = cnt_q - 1'b1;
                        end
                    end
                end
                gpt_pkg::MODE_CAPT: begin
                    if (tick) begin
                        cnt_d = cnt_q + 1'b1;              // wraps freely
                    end
                    if (pad_evt_in) begin
                        cap_d = cnt_q;
                        exp_d = 1'b1;
                    end
                end
                default: begin
                    state_d = ST_IDLE;                     // illegal mode halts
                end
            endcase
        end
    end

    // registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            pre_q   <= '0;
            cnt_q   <= '0;
            cap_q   <= '0;
            shots_q <= 8'h00;
            exp_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            pre_q   <= pre_d;
            cnt_q   <= cnt_d;
            cap_q   <= cap_d;
            shots_q <= shots_d;
            exp_q   <= exp_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign expire_out       = exp_q;
    assign stat_out.rsv     = '0;
    assign stat_out.running = (state_q == ST_RUN);
    assign stat_out.value   = (cfg_in.mode == gpt_pkg::MODE_CAPT) ? cap_q : cnt_q;

endmodule : gpt_unit

// file: design/gpt_top.sv
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

// Notes on behaviour
// - four timers, each own 24-bit counter
// - prescale field selects ratio 1 to 128
// - modes: single/multi-shot, free-run, pad capture
// - each timer has own expiry interrupt
// - per-timer configuration and status registers

module gpt_top (
    // clock and reset
    input  wire logic                              CLK_IN,
    input  wire logic                              RESET_N_IN,
    // apb slave
    input  wire logic                              PSEL_IN,
    input  wire logic                              PENABLE_IN,
    input  wire logic                              PWRITE_IN,
    input  wire logic [7:0]                        PADDR_IN,
    input  wire logic [31:0]                       PWDATA_IN,
    output logic      [31:0]                       PRDATA_OUT,
    output logic                                   PREADY_OUT,
    output logic                                   PSLVERR_OUT,
    // digital pads, asynchronous
    input  wire logic [gpt_pkg::PAD_COUNT-1:0]     DIGITAL_PAD_IN,
    // interrupts
    output logic      [gpt_pkg::NUM_TIMERS-1:0]    TIMER_IRQ_OUT,
    output logic                                   INT_OUT
);

    localparam int N = gpt_pkg::NUM_TIMERS;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    gpt_pkg::cfg_s                   cfg_q [N];
    gpt_pkg::cfg_s                   cfg_d [N];
    logic [gpt_pkg::CNT_W-1:0]       load_q [N];
    logic [gpt_pkg::CNT_W-1:0]       load_d [N];
    gpt_pkg::stat_s                  stat [N];
    logic [N-1:0]                    start_q, start_d;
    logic [N-1:0]                    expire, pad_evt;
    logic [N-1:0]                    ist_q, ist_d, imask_q, imask_d, ist_clr;
    logic [N-1:0]                    irq_q, irq_d;
    logic                            int_q, int_d;
    logic [31:0]                     prdata_q, prdata_d, rd_mux;
    logic                            pready_q, pready_d;
    logic                            pslverr_q, pslverr_d;
    logic                            setup, access, hit;
    logic                            tmr_area;
    logic [1:0]                      tmr_idx, tmr_reg;
    logic [gpt_pkg::PAD_COUNT-1:0]   pad_s1_q, pad_s2_q, pad_s3_q, pad_rise;

    // ------------------------------------------------------------
    // pad synchroniser and rising-edge detect
    // ------------------------------------------------------------

    // first stage feeds only the second stage; pads idle high on their
    // pull-ups, so reset to one or a false edge follows every reset
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pad_s1_q <= '1;
            pad_s2_q <= '1;
            pad_s3_q <= '1;
        end else begin
            pad_s1_q <= DIGITAL_PAD_IN;
            pad_s2_q <= pad_s1_q;
            pad_s3_q <= pad_s2_q;
        end
    end

    assign pad_rise = pad_s2_q & ~pad_s3_q;

    // each timer picks its own pad; an index past the last pad never fires
    always_comb begin
        pad_evt = '0;
        for (int i = 0; i < N; i++) begin
            if (int'(cfg_q[i].pad_sel) < gpt_pkg::PAD_COUNT) begin
                pad_evt[i] = pad_rise[cfg_q[i].pad_sel];
            end
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign setup    = PSEL_IN && !PENABLE_IN;
    assign access   = PSEL_IN && PENABLE_IN && pready_q;
    assign tmr_idx  = PADDR_IN[5:4];
    assign tmr_reg  = PADDR_IN[3:2];
    assign tmr_area = (PADDR_IN[7:6] == 2'b00) && (PADDR_IN[1:0] == 2'b00)
                      && (tmr_reg != 2'h3);
    assign hit      = tmr_area || (PADDR_IN == gpt_pkg::ADDR_INT_ST)
                      || (PADDR_IN == gpt_pkg::ADDR_INT_MSK);

    // read mux, sampled in the setup cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (tmr_area) begin
            unique case (tmr_reg)
                gpt_pkg::REG_CFG:  rd_mux = cfg_q[tmr_idx];
                gpt_pkg::REG_LOAD: rd_mux = {8'h00, load_q[tmr_idx]};
                gpt_pkg::REG_STAT: rd_mux = stat[tmr_idx];
                default:           rd_mux = 32'h0000_0000;
            endcase
        end else if (PADDR_IN == gpt_pkg::ADDR_INT_ST) begin
            rd_mux = {28'h000_0000, ist_q};
        end else if (PADDR_IN == gpt_pkg::ADDR_INT_MSK) begin
            rd_mux = {28'h000_0000, imask_q};
        end
    end

    // ------------------------------------------------------------
    // apb handshake: answer registered in the setup cycle,
    // so the access phase always completes on its first edge
    // ------------------------------------------------------------
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup && !hit;
        prdata_d  = (setup && !PWRITE_IN) ? rd_mux : prdata_q;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // configuration and load registers
    // ------------------------------------------------------------

    // a config write also restarts the timer one cycle later,
    // once the new mode and prescale are already in place
    always_comb begin
        for (int i = 0; i < N; i++) begin
            cfg_d[i]   = cfg_q[i];
            load_d[i]  = load_q[i];
            start_d[i] = 1'b0;
            if (access && PWRITE_IN && tmr_area && (int'(tmr_idx) == i)) begin
                if (tmr_reg == gpt_pkg::REG_CFG) begin
                    cfg_d[i]   = gpt_pkg::cfg_s'(PWDATA_IN & gpt_pkg::CFG_WMASK);
                    start_d[i] = 1'b1;
                end
                if (tmr_reg == gpt_pkg::REG_LOAD) begin
                    load_d[i] = PWDATA_IN[gpt_pkg::CNT_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            for (int i = 0; i < N; i++) begin
                cfg_q[i]  <= gpt_pkg::cfg_s'(gpt_pkg::CFG_RESET);
                load_q[i] <= gpt_pkg::LOAD_RESET;
            end
            start_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                cfg_q[i]  <= cfg_d[i];
                load_q[i] <= load_d[i];
            end
            start_q <= start_d;
        end
    end

    // ------------------------------------------------------------
    // timer instances
    // ------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : g_tmr
        gpt_unit u_tmr (
            .clk_in     (CLK_IN),
            .reset_n_in (RESET_N_IN),
            .cfg_in     (cfg_q[g]),
            .load_in    (load_q[g]),
            .start_in   (start_q[g]),
            .pad_evt_in (pad_evt[g]),
            .stat_out   (stat[g]),
            .expire_out (expire[g])
        );
    end

    // ------------------------------------------------------------
    // interrupt status, mask and outputs
    // ------------------------------------------------------------

    // read clears only the bits that were returned; a new expiry
    // in the same cycle survives because set wins over clear
    always_comb begin
        ist_clr = '0;
        imask_d = imask_q;
        if (access && !PWRITE_IN && (PADDR_IN == gpt_pkg::ADDR_INT_ST)) begin
            ist_clr = prdata_q[N-1:0];
        end
        if (access && PWRITE_IN && (PADDR_IN == gpt_pkg::ADDR_INT_MSK)) begin
            imask_d = PWDATA_IN[N-1:0];
        end
        ist_d = (ist_q & ~ist_clr) | expire;
        irq_d = ist_d & imask_d;
        int_d = |irq_d;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ist_q   <= '0;
            imask_q <= gpt_pkg::MASK_RESET;
            irq_q   <= '0;
            int_q   <= 1'b0;
        end else begin
            ist_q   <= ist_d;
            imask_q <= imask_d;
            irq_q   <= irq_d;
            int_q   <= int_d;
        end
    end

    // ------------------------------------------------------------
    // output drive, all from flops
    // ------------------------------------------------------------
    assign PRDATA_OUT    = prdata_q;
    assign PREADY_OUT    = pready_q;
    assign PSLVERR_OUT   = pslverr_q;
    assign TIMER_IRQ_OUT = irq_q;
    assign INT_OUT       = int_q;

endmodule : gpt_top

// file: dv/gpt_top_asserts.sv
`timescale 1ns/10ps

module gpt_top_asserts (
    // clock and reset
    input wire logic                           CLK_IN,
    input wire logic                           RESET_N_IN,
    // apb
    input wire logic                           PSEL_IN,
    input wire logic                           PENABLE_IN,
    input wire logic                           PWRITE_IN,
    input wire logic [7:0]                     PADDR_IN,
    input wire logic [31:0]                    PWDATA_IN,
    input wire logic [31:0]                    PRDATA_OUT,
    input wire logic                           PREADY_OUT,
    input wire logic                           PSLVERR_OUT,
    // interrupts
    input wire logic [gpt_pkg::NUM_TIMERS-1:0] TIMER_IRQ_OUT,
    input wire logic                           INT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    sequence setup_s;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence done_s;
        PSEL_IN && PENABLE_IN && PREADY_OUT;
    endsequence

    // ------------------------------------------------------------
    // register bus answers
    // ------------------------------------------------------------
    chk_ready_after_setup: assert property (setup_s |=> PREADY_OUT)
        else $error("ready missing after setup");
    chk_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    chk_ready_needs_setup: assert property (PREADY_OUT |->
        $past(PSEL_IN && !PENABLE_IN))
        else $error("ready without setup");
    chk_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error outside access");
    chk_bad_addr_err: assert property (setup_s ##0 (PADDR_IN[1:0] != 2'h0 ||
        PADDR_IN > gpt_pkg::ADDR_INT_MSK) |=> PSLVERR_OUT)
        else $error("unmapped address accepted");
    chk_err_rdata_zero: assert property (done_s ##0 (PSLVERR_OUT && !PWRITE_IN)
        |-> PRDATA_OUT == 32'h0000_0000)
        else $error("refused read returned data");
    // read data may only move after a read setup, else software sees garbage
    chk_rdata_holds: assert property (!(PSEL_IN && !PENABLE_IN && !PWRITE_IN)
        |=> $stable(PRDATA_OUT))
        else $error("read data changed");

    // ------------------------------------------------------------
    // interrupt lines
    // ------------------------------------------------------------
    chk_int_follows: assert property ($rose(|TIMER_IRQ_OUT) |-> ##[0:1] INT_OUT)
        else $error("summary irq missing");
    chk_int_quiet: assert property ((TIMER_IRQ_OUT == '0)[*2] |-> !INT_OUT)
        else $error("summary irq without cause");
    chk_mask_off_quiet: assert property (done_s ##0 (PWRITE_IN &&
        PADDR_IN == gpt_pkg::ADDR_INT_MSK && PWDATA_IN == 32'h0000_0000)
        |-> ##2 TIMER_IRQ_OUT == '0)
        else $error("masked irq still high");
endmodule : gpt_top_asserts

bind gpt_top gpt_top_asserts u_chk (.CLK_IN, .RESET_N_IN, .PSEL_IN, .PENABLE_IN,
    .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
    .TIMER_IRQ_OUT, .INT_OUT);

// file: dv/gpt_pad_model.sv
`timescale 1ns/10ps

module gpt_pad_model (
    // clock
    input  wire logic        clk_in,
    // command from bench
    input  wire logic        fire_in,
    input  wire logic [5:0]  sel_in,
    // pad levels
    output logic      [35:0] pad_out
);
    int low_cnt = 0;

    // pads are pulled up; a short dip and release makes the rising edge
    always @(posedge clk_in) begin
        if (fire_in) begin
            low_cnt <= 4;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end
    end

    // only the chosen pad dips, so a wrong select shows as no capture
    assign pad_out = (low_cnt != 0) ? ~(36'h1 << sel_in) : '1;
endmodule : gpt_pad_model

// file: dv/test_gpt_top.sv
`timescale 1ns/10ps

module test_gpt_top;
    logic        clk, rst_n, psel, penable, pwrite, fire;
    logic        pready, pslverr, intr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [35:0] pads;
    logic [3:0]  irq;
    logic [5:0]  sel;
    logic [7:0]  bad [3] = '{8'h0C, 8'h48, 8'h41};
    int          err_count, total_checks;

    gpt_top DUT (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DIGITAL_PAD_IN(pads),
        .TIMER_IRQ_OUT(irq), .INT_OUT(intr));

    gpt_pad_model u_pad (.clk_in(clk), .fire_in(fire), .sel_in(sel), .pad_out(pads));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask : check

    task automatic end_of_test;
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // one transfer; request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] ra(input int i, input logic [1:0] r);
        return 8'(i) * gpt_pkg::TMR_STRIDE + 8'({r, 2'b00});
    endfunction : ra

    // cycles from restart to expiry
    function automatic int period(input int n, input int p);
        return (n + 1) << p;
    endfunction : period

    // bounded wait, so a dead timer cannot hang the run
    task automatic wait_irq(input int i, input int lim, output int n);
        n = 0;
        while (irq[i] !== 1'b1 && n < lim) begin
            n++;
            @(posedge clk);
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        int n, t, p, r, k, w;
        logic [31:0] v;
        {rst_n, psel, penable, pwrite, fire, paddr, pwdata, sel} = '0;
        err_count = 0;
        total_checks = 0;
        void'($urandom(81));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // reset values of every block
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra(i, gpt_pkg::REG_CFG), 32'h0);
            check("cfg_reset", gpt_pkg::CFG_RESET, rd);
            apb(1'b0, ra(i, gpt_pkg::REG_LOAD), 32'h0);
            check("load_reset", {8'h00, gpt_pkg::LOAD_RESET}, rd);
            apb(1'b0, ra(i, gpt_pkg::REG_STAT), 32'h0);
            check("stat_reset", 32'h0, rd);
        end
        apb(1'b0, gpt_pkg::ADDR_INT_MSK, 32'h0);
        check("mask_reset", 32'(gpt_pkg::MASK_RESET), rd);
        // refused places, writes included
        foreach (bad[j]) begin
            apb(1'b0, bad[j], 32'h0);
            check("bad_err", 32'h1, 32'(err));
            check("bad_data", 32'h0, rd);
            apb(1'b1, bad[j], $urandom);
            check("bad_wr_err", 32'h1, 32'(err));
        end
        // random config read-back, enable kept off
        v = $urandom & ~32'h20;
        apb(1'b1, ra(3, gpt_pkg::REG_CFG), v);
        apb(1'b0, ra(3, gpt_pkg::REG_CFG), 32'h0);
        check("cfg_back", v & gpt_pkg::CFG_WMASK, rd);
        apb(1'b1, ra(3, gpt_pkg::REG_CFG), 32'h0);
        // illegal mode code: timer runs one cycle, then halts
        apb(1'b1, ra(0, gpt_pkg::REG_CFG), 32'h38);
        repeat (2) @(posedge clk);
        apb(1'b0, ra(0, gpt_pkg::REG_STAT), 32'h0);
        check("bad_mode_idle", 32'h0, 32'(rd[24]));
        apb(1'b1, ra(0, gpt_pkg::REG_CFG), 32'h0);
        // free-run on each timer, prescale ends included
        for (int i = 0; i < 4; i++) begin
            n = 1 + $urandom % 20;
            p = (i == 0) ? 0 : (i == 3) ? 7 : $urandom % 4;
            t = period(n, p);
            apb(1'b1, gpt_pkg::ADDR_INT_MSK, 32'hF);
            apb(1'b1, ra(i, gpt_pkg::REG_LOAD), 32'(n));
            apb(1'b1, ra(i, gpt_pkg::REG_CFG), 32'(p) | 32'h28);
            wait_irq(i, t + 20, k);
            check("expiry_time", 32'h1, 32'(k >= t && k <= t + 5));
            check("irq_lines", 32'h1 << i, 32'(irq));
            check("irq_summary", 32'h1, 32'(intr));
            apb(1'b0, gpt_pkg::ADDR_INT_ST, 32'h0);
            check("int_status", 32'h1 << i, rd);
            apb(1'b1, gpt_pkg::ADDR_INT_MSK, 32'h0);
            repeat (t + 6) @(posedge clk);
            check("irq_masked", 32'h0, 32'(irq));
            apb(1'b0, gpt_pkg::ADDR_INT_ST, 32'h0);
            check("free_reload", 32'h1 << i, rd);
            apb(1'b1, ra(i, gpt_pkg::REG_CFG), 32'h0);
            apb(1'b0, gpt_pkg::ADDR_INT_ST, 32'h0);
        end
        // multi-shot: repeats plus one expiries, then idle
        r = $urandom % 3;
        apb(1'b1, gpt_pkg::ADDR_INT_MSK, 32'hF);
        apb(1'b1, ra(1, gpt_pkg::REG_LOAD), 32'h5);
        apb(1'b1, ra(1, gpt_pkg::REG_CFG), (32'(r) << 16) | 32'h21);
        for (int j = 0; j <= r; j++) begin
            wait_irq(1, 40, k);
            check("shot_fired", 32'h1, 32'(irq[1]));
            apb(1'b0, gpt_pkg::ADDR_INT_ST, 32'h0);
            check("shot_status", 32'h2, rd);
            repeat (2) @(posedge clk);
        end
        repeat (60) @(posedge clk);
        check("shot_stopped", 32'h0, 32'(irq));
        apb(1'b0, ra(1, gpt_pkg::REG_STAT), 32'h0);
        check("shot_idle", 32'h0, 32'(rd[24]));
        // capture on a random pad
        k = $urandom % 36;
        sel <= 6'(k);
        apb(1'b1, ra(2, gpt_pkg::REG_CFG), (32'(k) << 8) | 32'h30);
        w = 20 + $urandom % 40;
        repeat (w) @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        wait_irq(2, 40, n);
        check("capture_irq", 32'h1, 32'(irq[2]));
        apb(1'b0, ra(2, gpt_pkg::REG_STAT), 32'h0);
        check("capture_val", 32'h1, 32'(rd[23:0] >= w + 3 && rd[23:0] <= w + 15));
        end_of_test;
    end

    // hang guard, well past the longest expected run
    initial begin
        #200000;
        err_count++;
        end_of_test;
    end
endmodule : test_gpt_top
